// *** hdl/sfm_top.v ***
`timescale 1ns/1ps
`include "sfm_consts.vh"
module sfm_top #(
  parameter [23:0] RESTART_CYCLES = `SFM_T_RESTART_MS * 1000 * `SFM_MCLK_MHZ
) (
  input wire MCLK,
  input wire RSTN,
  input wire CE,
  input wire UV_CMP,
  input wire OV_CMP,
  input wire CP_BAD,
  input wire FAIL_MODE,
  output reg [4:0] OUT_EN,
  output reg [4:0] INRUSH_START,
  output reg DEV_FAULT,
  output reg IRQ,
  input wire [7:0] AWADDR,
  input wire AWVALID,
  output reg AWREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output reg WREADY,
  output reg [1:0] BRESP,
  output reg BVALID,
  input wire BREADY,
  input wire [7:0] ARADDR,
  input wire ARVALID,
  output reg ARREADY,
  output reg [31:0] RDATA,
  output reg [1:0] RRESP,
  output reg RVALID,
  input wire RREADY
);
  localparam integer UVOV_DGL_NUM = `SFM_T_UVOV_DGL_NS * `SFM_MCLK_MHZ / 1000;
  localparam integer CP_DGL_NUM = `SFM_T_CP_DGL_NS * `SFM_MCLK_MHZ / 1000;
  localparam [15:0] UVOV_DGL_RST = UVOV_DGL_NUM[15:0];
  localparam [15:0] CP_DGL_RST = CP_DGL_NUM[15:0];

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function is_mapped;
    input [7:0] addr;
    begin
      is_mapped = (addr[7:5] == 3'b000) && (addr[1:0] == 2'b00);
    end
  endfunction

  function [31:0] strb_merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      strb_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          strb_merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  // ----------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------
  reg [1:0] rst_pipe;
  wire rst_n = rst_pipe[1];

  // Release is not gated by CE so the device leaves reset even while frozen
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  reg [2:0] cmp_meta;
  reg [2:0] cmp_sync;
  wire uv_sync = cmp_sync[0];
  wire ov_sync = cmp_sync[1];
  wire cp_sync = cmp_sync[2];

  // Pump starts as bad so the settle logic waits for a real low sample
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      cmp_meta <= 3'b100;
      cmp_sync <= 3'b100;
    end else if (CE) begin
      cmp_meta <= {CP_BAD, OV_CMP, UV_CMP};
      cmp_sync <= cmp_meta;
    end
  end

  // ----------------------------------------
  // Deglitch filters
  // ----------------------------------------
  reg [15:0] uvov_limit;
  reg [15:0] cp_limit;
  wire uv_trip;
  wire ov_trip;
  wire cp_trip;

  sfm_deglitch u_uv_dgl (
    .clk(MCLK),
    .rst_n(rst_n),
    .ce(CE),
    .raw(uv_sync),
    .limit(uvov_limit),
    .trip(uv_trip)
  );

  sfm_deglitch u_ov_dgl (
    .clk(MCLK),
    .rst_n(rst_n),
    .ce(CE),
    .raw(ov_sync),
    .limit(uvov_limit),
    .trip(ov_trip)
  );

  sfm_deglitch u_cp_dgl (
    .clk(MCLK),
    .rst_n(rst_n),
    .ce(CE),
    .raw(cp_sync),
    .limit(cp_limit),
    .trip(cp_trip)
  );

  reg uv_trip_d;
  reg ov_trip_d;
  reg cp_trip_d;
  wire uv_rise = uv_trip & ~uv_trip_d;
  wire ov_rise = ov_trip & ~ov_trip_d;
  wire cp_rise = cp_trip & ~cp_trip_d;

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  reg [7:0] aw_addr;
  reg aw_got;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_got;
  wire wr_fire = aw_got & w_got & ~BVALID;
  wire rd_fire = ARVALID & ARREADY;
  wire rd_quick = rd_fire && (ARADDR == `SFM_OFS_QUICK_STATUS);
  wire rd_dev = rd_fire && (ARADDR == `SFM_OFS_DEV_STATUS);
  wire wr_ctrl = wr_fire && (aw_addr == `SFM_OFS_OUT_CTRL) && w_strb[0];
  wire wr_irq_clr = wr_fire && (aw_addr == `SFM_OFS_IRQ_CLEAR) && w_strb[0];

  reg [4:0] cmd_on;
  reg supply_low_flag;
  reg supply_high_flag;
  reg pump_fault_flag;
  reg pump_settled;
  reg fail_hold;
  reg [23:0] restart_cnt;
  reg [3:0] irq_status;
  reg [3:0] irq_enable;
  reg [31:0] rd_value;
  wire [31:0] irq_en_merged = strb_merge({28'h0000000, irq_enable}, w_data, w_strb);

  always @* begin
    rd_value = 32'h00000000;
    case (ARADDR)
      `SFM_OFS_OUT_CTRL: rd_value[4:0] = cmd_on;
      `SFM_OFS_QUICK_STATUS: begin
        rd_value[`SFM_QS_PUMP] = pump_fault_flag;
        rd_value[`SFM_QS_SUMMARY] = DEV_FAULT;
      end
      `SFM_OFS_DEV_STATUS: begin
        rd_value[`SFM_DS_LOW] = supply_low_flag;
        rd_value[`SFM_DS_HIGH] = supply_high_flag;
        rd_value[`SFM_DS_SUMMARY] = DEV_FAULT;
        rd_value[`SFM_DS_FAIL_MODE] = FAIL_MODE;
      end
      `SFM_OFS_OUT_STATE: begin
        rd_value[4:0] = OUT_EN;
        rd_value[`SFM_OS_CMD_LSB +: 5] = cmd_on;
        rd_value[`SFM_OS_UV] = uv_trip;
        rd_value[`SFM_OS_OV] = ov_trip;
        rd_value[`SFM_OS_CP] = cp_trip;
        rd_value[`SFM_OS_SETTLED] = pump_settled;
        rd_value[`SFM_OS_HOLD] = fail_hold;
      end
      `SFM_OFS_DEGLITCH: rd_value = {cp_limit, uvov_limit};
      `SFM_OFS_IRQ_STATUS: rd_value[3:0] = irq_status;
      `SFM_OFS_IRQ_ENABLE: rd_value[3:0] = irq_enable;
      default: rd_value = 32'h00000000;
    endcase
  end

  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      BVALID <= 1'b0;
      BRESP <= `SFM_RESP_OKAY;
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RRESP <= `SFM_RESP_OKAY;
      RDATA <= 32'h00000000;
      aw_addr <= 8'h00;
      aw_got <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      w_got <= 1'b0;
      uvov_limit <= UVOV_DGL_RST;
      cp_limit <= CP_DGL_RST;
      irq_enable <= `SFM_RST_IRQ_ENABLE;
    end else if (CE) begin
      if (AWVALID && AWREADY) begin
        aw_addr <= AWADDR;
        aw_got <= 1'b1;
        AWREADY <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_data <= WDATA;
        w_strb <= WSTRB;
        w_got <= 1'b1;
        WREADY <= 1'b0;
      end
      if (wr_fire) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= is_mapped(aw_addr) ? `SFM_RESP_OKAY : `SFM_RESP_SLVERR;
        if (aw_addr == `SFM_OFS_DEGLITCH) begin
          {cp_limit, uvov_limit} <= strb_merge({cp_limit, uvov_limit}, w_data, w_strb);
        end
        if (aw_addr == `SFM_OFS_IRQ_ENABLE) begin
          irq_enable <= irq_en_merged[3:0];
        end
      end
      // Ready returns only after the response is taken: one write in flight
      if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
      if (rd_fire) begin
        RDATA <= rd_value;
        RRESP <= is_mapped(ARADDR) ? `SFM_RESP_OKAY : `SFM_RESP_SLVERR;
        RVALID <= 1'b1;
        ARREADY <= 1'b0;
      end
      if (RVALID && RREADY) begin
        RVALID <= 1'b0;
        ARREADY <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Fault flags
  // ----------------------------------------
  // Read data is captured at the same edge, so the clearing read still sees the flag
  wire next_low = uv_trip | (supply_low_flag & ~(rd_dev & ~uv_sync));
  wire next_high = ov_trip | (supply_high_flag & ~(rd_dev & ~ov_sync));
  wire next_pump = cp_trip | (pump_fault_flag & ~(rd_quick & ~cp_sync));

  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      supply_low_flag <= 1'b0;
      supply_high_flag <= 1'b0;
      pump_fault_flag <= 1'b0;
      DEV_FAULT <= 1'b0;
      uv_trip_d <= 1'b0;
      ov_trip_d <= 1'b0;
      cp_trip_d <= 1'b0;
    end else if (CE) begin
      supply_low_flag <= next_low;
      supply_high_flag <= next_high;
      pump_fault_flag <= next_pump;
      DEV_FAULT <= next_low | next_high | next_pump;
      uv_trip_d <= uv_trip;
      ov_trip_d <= ov_trip;
      cp_trip_d <= cp_trip;
    end
  end

  // ----------------------------------------
  // Output control and restart
  // ----------------------------------------
  wire restart_due = fail_hold && (restart_cnt >= RESTART_CYCLES - 24'h000001);
  wire restart_go = restart_due & ~uv_trip & ~uv_sync;
  wire block = uv_trip | cp_trip | ~pump_settled;
  wire [4:0] next_out_en = cmd_on & {5{~block & ~fail_hold}};

  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      cmd_on <= `SFM_RST_OUT_CTRL;
      pump_settled <= 1'b0;
      fail_hold <= 1'b0;
      restart_cnt <= 24'h000000;
      OUT_EN <= 5'h00;
      INRUSH_START <= 5'h00;
    end else if (CE) begin
      if (!cp_sync) begin
        pump_settled <= 1'b1;
      end
      // Commands are stored even while blocked and act once the block lifts
      if (wr_ctrl) begin
        cmd_on <= w_data[4:0];
      end else if (uv_rise && !FAIL_MODE) begin
        cmd_on <= 5'h00;
      end
      if (uv_rise && FAIL_MODE) begin
        fail_hold <= 1'b1;
      end else if (restart_go) begin
        fail_hold <= 1'b0;
      end
      // Each attempt waits a full interval; a still-low supply rearms it
      if (!fail_hold || restart_due) begin
        restart_cnt <= 24'h000000;
      end else begin
        restart_cnt <= restart_cnt + 24'h000001;
      end
      OUT_EN <= next_out_en;
      INRUSH_START <= next_out_en & ~OUT_EN;
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  wire [3:0] irq_event = {restart_go, cp_rise, ov_rise, uv_rise};
  wire [3:0] irq_clr = wr_irq_clr ? w_data[3:0] : 4'h0;
  wire [3:0] next_irq_status = irq_event | (irq_status & ~irq_clr);

  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= 4'h0;
      IRQ <= 1'b0;
    end else if (CE) begin
      irq_status <= next_irq_status;
      IRQ <= |(next_irq_status & irq_enable);
    end
  end
endmodule // sfm_top

// *** hdl/sfm_consts.vh ***
`ifndef SFM_CONSTS_VH
`define SFM_CONSTS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SFM_OFS_OUT_CTRL 8'h00
`define SFM_OFS_QUICK_STATUS 8'h04
`define SFM_OFS_DEV_STATUS 8'h08
`define SFM_OFS_OUT_STATE 8'h0c
`define SFM_OFS_DEGLITCH 8'h10
`define SFM_OFS_IRQ_STATUS 8'h14
`define SFM_OFS_IRQ_CLEAR 8'h18
`define SFM_OFS_IRQ_ENABLE 8'h1c
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SFM_QS_PUMP 0
`define SFM_QS_SUMMARY 1
`define SFM_DS_LOW 0
`define SFM_DS_HIGH 1
`define SFM_DS_SUMMARY 2
`define SFM_DS_FAIL_MODE 3
`define SFM_OS_CMD_LSB 8
`define SFM_OS_UV 16
`define SFM_OS_OV 17
`define SFM_OS_CP 18
`define SFM_OS_SETTLED 19
`define SFM_OS_HOLD 20
`define SFM_IRQ_UV 0
`define SFM_IRQ_OV 1
`define SFM_IRQ_CP 2
`define SFM_IRQ_RESTART 3
// ----------------------------------------
// Reset values and bus answers
// ----------------------------------------
`define SFM_RST_OUT_CTRL 5'h00
`define SFM_RST_IRQ_ENABLE 4'h0
`define SFM_RESP_OKAY 2'b00
`define SFM_RESP_SLVERR 2'b10
// ----------------------------------------
// Timing
// ----------------------------------------
`define SFM_MCLK_MHZ 200
`define SFM_T_UVOV_DGL_NS 3500
`define SFM_T_CP_DGL_NS 4000
`define SFM_T_RESTART_MS 64
`endif

// *** hdl/sfm_deglitch.v ***
`timescale 1ns/1ps
module sfm_deglitch (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire raw,
  input wire [15:0] limit,
  output reg trip
);
  reg [15:0] count;

  // Any low cycle restarts the count, so only an unbroken assertion trips
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 16'h0000;
      trip <= 1'b0;
    end else if (ce) begin
      if (!raw) begin
        count <= 16'h0000;
        trip <= 1'b0;
      end else if (count >= limit) begin
        trip <= 1'b1;
      end else begin
        count <= count + 16'h0001;
      end
    end
  end
endmodule // sfm_deglitch

// *** test/sfm_monitor.sv ***
`timescale 1ns/1ps
module sfm_monitor #(
  parameter L = 10
) (
  input wire MCLK,
  input wire RSTN,
  input wire UV_CMP,
  input wire OV_CMP,
  input wire CP_BAD,
  input wire FAIL_MODE,
  input wire [4:0] OUT_EN,
  input wire [4:0] INRUSH_START,
  input wire DEV_FAULT,
  input wire ARVALID,
  input wire ARREADY,
  input wire RVALID,
  input wire BVALID
);
  // ----
  // Run lengths; L must match the deglitch limits the bench programs
  // ----
  reg [7:0] uv_cnt;
  reg [7:0] cp_cnt;
  reg [7:0] any_cnt;
  reg [7:0] quiet;
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      uv_cnt <= 8'h00;
      cp_cnt <= 8'h00;
      any_cnt <= 8'h00;
      quiet <= 8'h00;
    end else begin
      uv_cnt <= UV_CMP ? uv_cnt + 8'h01 : 8'h00;
      cp_cnt <= CP_BAD ? cp_cnt + 8'h01 : 8'h00;
      any_cnt <= (UV_CMP | OV_CMP | CP_BAD) ? any_cnt + 8'h01 : 8'h00;
      quiet <= (UV_CMP | CP_BAD) ? 8'h00 : quiet + {7'h00, quiet != 8'h0f};
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  a_uv_shut_off: assert property (uv_cnt >= L + 4 |-> OUT_EN == 5'h00)
    else $error("outputs on after undervoltage");
  a_uv_flag_set: assert property (uv_cnt >= L + 4 |-> DEV_FAULT)
    else $error("no fault flag after undervoltage");
  a_cp_shut_off: assert property (cp_cnt >= L + 4 |-> OUT_EN == 5'h00)
    else $error("outputs on after pump fault");
  a_cp_flag_set: assert property (cp_cnt >= L + 4 |-> DEV_FAULT)
    else $error("no fault flag after pump fault");
  a_inrush_pulse: assert property (INRUSH_START == (OUT_EN & ~$past(OUT_EN)))
    else $error("inrush pulse mismatch");
  a_no_self_restart: assert property ($rose(|OUT_EN) && !FAIL_MODE && quiet == 8'h0f |-> $past(BVALID))
    else $error("outputs restarted without a write");
  a_short_glitch: assert property ($rose(DEV_FAULT) |-> any_cnt > L)
    else $error("fault flag after short pulse");
  a_clear_on_read: assert property ($fell(DEV_FAULT) |-> $past(ARVALID && ARREADY))
    else $error("fault flag dropped without a read");
  a_read_answer: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
    else $error("read not answered next cycle");
endmodule // sfm_monitor
bind sfm_top sfm_monitor MON (.MCLK(MCLK), .RSTN(RSTN), .UV_CMP(UV_CMP), .OV_CMP(OV_CMP), .CP_BAD(CP_BAD),
  .FAIL_MODE(FAIL_MODE), .OUT_EN(OUT_EN), .INRUSH_START(INRUSH_START), .DEV_FAULT(DEV_FAULT),
  .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID), .BVALID(BVALID));

// *** test/sfm_supply_model.sv ***
`timescale 1ns/1ps
module sfm_supply_model (
  input wire clk,
  input wire want_uv,
  input wire want_ov,
  input wire want_cp,
  output reg uv_cmp = 1'b0,
  output reg ov_cmp = 1'b0,
  output reg cp_bad = 1'b1
);
  // Comparators move just after an edge; cp_bad starts high, so the pump starts out unsettled
  always @(posedge clk) begin
    uv_cmp <= want_uv;
    ov_cmp <= want_ov;
    cp_bad <= want_cp;
  end
endmodule // sfm_supply_model

// *** test/sfm_tb.sv ***
`timescale 1ns/1ps
`include "sfm_consts.vh"
module tb;
  reg mclk = 1'b0;
  reg rstn = 1'b0;
  reg fail_mode = 1'b0;
  reg want_uv = 1'b0;
  reg want_ov = 1'b0;
  reg want_cp = 1'b1;
  reg [7:0] awaddr = 8'h00;
  reg awvalid = 1'b0;
  reg [31:0] wdata = 32'h0;
  reg wvalid = 1'b0;
  reg [7:0] araddr = 8'h00;
  reg arvalid = 1'b0;
  wire uv, ov, cp, dev_fault, irq, awready, wready, bvalid, arready, rvalid;
  wire [4:0] out_en;
  wire [4:0] inrush;
  wire [1:0] bresp;
  wire [1:0] rresp;
  wire [31:0] rdata;
  integer fail_count = 0;
  integer samples_checked = 0;
  integer cyc = 0;
  integer n;
  always #2.5 mclk = ~mclk;
  sfm_supply_model PSU (.clk(mclk), .want_uv(want_uv), .want_ov(want_ov), .want_cp(want_cp),
    .uv_cmp(uv), .ov_cmp(ov), .cp_bad(cp));
  sfm_top #(.RESTART_CYCLES(24'd50)) DUT (.MCLK(mclk), .RSTN(rstn), .CE(1'b1), .UV_CMP(uv), .OV_CMP(ov),
    .CP_BAD(cp), .FAIL_MODE(fail_mode), .OUT_EN(out_en), .INRUSH_START(inrush), .DEV_FAULT(dev_fault),
    .IRQ(irq), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(1'b1), .ARADDR(araddr),
    .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(1'b1));
  // ----
  // Access tasks
  // ----
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("wrong value at %0t: %h expected %h", $time, g, e);
      end
    end
  endtask
  task tick(input integer k);
    repeat (k) @(posedge mclk);
  endtask
  // Ready lines are tied high, so each answer is taken at the edge it is seen
  task wr(input [7:0] a, input [31:0] v, input [1:0] r = `SFM_RESP_OKAY);
    begin
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
        @(posedge mclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      chk({30'h0, bresp}, {30'h0, r});
    end
  endtask
  task rd(input [7:0] a, input [31:0] e, input [1:0] r = `SFM_RESP_OKAY);
    begin
      araddr <= a;
      arvalid <= 1'b1;
      do begin
        @(posedge mclk);
        if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      chk(rdata, e);
      chk({30'h0, rresp}, {30'h0, r});
    end
  endtask
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc > 5000) begin
      fail_count = fail_count + 1;
      finish_test;
    end
  end
  // ----
  // Sequence
  // ----
  initial begin
    tick(12);
    rstn <= 1'b1;
    tick(4);
    wr(`SFM_OFS_OUT_CTRL, 32'h1f);
    chk({27'h0, out_en}, 32'h0);
    want_cp <= 1'b0;
    tick(8);
    chk({27'h0, out_en}, 32'h1f);
    rd(`SFM_OFS_DEGLITCH, 32'h032002bc);
    wr(`SFM_OFS_DEGLITCH, 32'h000a000a);
    rd(8'h24, 32'h0, `SFM_RESP_SLVERR);
    wr(8'h24, 32'h1, `SFM_RESP_SLVERR);
    wr(`SFM_OFS_QUICK_STATUS, 32'h3);
    want_cp <= 1'b1;
    tick(30);
    chk({27'h0, out_en}, 32'h0);
    wr(`SFM_OFS_OUT_CTRL, 32'h0a);
    want_cp <= 1'b0;
    tick(8);
    chk({27'h0, out_en}, 32'h0a);
    rd(`SFM_OFS_QUICK_STATUS, 32'h3);
    rd(`SFM_OFS_QUICK_STATUS, 32'h0);
    want_uv <= 1'b1;
    tick(30);
    chk({27'h0, out_en}, 32'h0);
    rd(`SFM_OFS_DEV_STATUS, 32'h5);
    rd(`SFM_OFS_DEV_STATUS, 32'h5);
    want_uv <= 1'b0;
    tick(60);
    chk({27'h0, out_en}, 32'h0);
    rd(`SFM_OFS_DEV_STATUS, 32'h5);
    rd(`SFM_OFS_DEV_STATUS, 32'h0);
    wr(`SFM_OFS_OUT_CTRL, 32'h1f);
    tick(2);
    chk({27'h0, out_en}, 32'h1f);
    want_uv <= 1'b1;
    tick(8);
    want_uv <= 1'b0;
    tick(20);
    rd(`SFM_OFS_DEV_STATUS, 32'h0);
    want_ov <= 1'b1;
    tick(30);
    rd(`SFM_OFS_DEV_STATUS, 32'h6);
    chk({31'h0, dev_fault}, 32'h1);
    want_ov <= 1'b0;
    tick(5);
    rd(`SFM_OFS_DEV_STATUS, 32'h6);
    rd(`SFM_OFS_DEV_STATUS, 32'h0);
    fail_mode <= 1'b1;
    want_uv <= 1'b1;
    tick(30);
    chk({27'h0, out_en}, 32'h0);
    want_uv <= 1'b0;
    n = 0;
    while (out_en !== 5'h1f && n < 200) begin
      @(posedge mclk);
      n = n + 1;
    end
    chk({31'h0, n <= 60}, 32'h1);
    chk({31'h0, n >= 24 && n <= 48}, 32'h1);
    rd(`SFM_OFS_DEV_STATUS, 32'hd);
    rd(`SFM_OFS_OUT_STATE, 32'h00081f1f);
    rd(`SFM_OFS_IRQ_STATUS, 32'hf);
    chk({31'h0, irq}, 32'h0);
    wr(`SFM_OFS_IRQ_ENABLE, 32'h8);
    tick(2);
    chk({31'h0, irq}, 32'h1);
    wr(`SFM_OFS_IRQ_CLEAR, 32'h8);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    rd(`SFM_OFS_IRQ_STATUS, 32'h7);
    rd(`SFM_OFS_IRQ_ENABLE, 32'h8);
    finish_test;
  end
endmodule // tb
